// ### inc/bsg_defs.vh
// Constants for the boot strap capture and general purpose pin block.
`ifndef BSG_DEFS_VH
`define BSG_DEFS_VH
`define BSG_NPINS 16
`define BSG_STRAP_RST 16'h0001
`define BSG_BYTE_ORDER_BIT 0
`define BSG_BOOTDEV_LSB 1
`define BSG_BOOTDEV_MSB 3
`define BSG_DEVCFG_LSB 4
`define BSG_DEVCFG_MSB 5
`define BSG_DEVSPEC_LSB 6
`define BSG_DEVSPEC_MSB 10
`define BSG_PLLI2C_LSB 11
`define BSG_PLLI2C_MSB 13
`define BSG_PCIE_LSB 14
`define BSG_PCIE_MSB 15
`define BSG_SERIAL_LINK_ID_SELECT_MASK 16'h0030
`define BSG_BOOT_SRIO 3'h1
`define BSG_BOOT_ETH 3'h2
`define BSG_BOOT_I2C 3'h3
`define BSG_INIT_NS 64
`define BSG_CLK_NS 8
`define BSG_INIT_CYC ((`BSG_INIT_NS + `BSG_CLK_NS - 1) / `BSG_CLK_NS)
`define BSG_ST_RESET 2'h0
`define BSG_ST_INIT 2'h1
`define BSG_ST_RUN 2'h2
`endif

// ### rtl/bsg_sync3.v
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
module bsg_sync3 #(
  parameter W = 16,
  parameter [15:0] RST = 16'h0000
) (
  input wire clk, // System clock.
  input wire rst_n, // Asynchronous reset, active low.
  input wire [W-1:0] d, // Asynchronous input.
  output reg [W-1:0] q // Filtered, synchronised value.
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // The first stage is read only by the second; a change counts once stages two and three agree.
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[i] <= RST[i];
          s2_r[i] <= RST[i];
          s3_r[i] <= RST[i];
          q[i] <= RST[i];
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule // bsg_sync3

// ### rtl/bsg_gpio_bit.v
// One general purpose pin: edge event detection, gated by direction; the output level is not used here.
`timescale 1ns/10ps
module bsg_gpio_bit (
  input wire clk, // System clock.
  input wire rst_n, // Block reset, active low.
  input wire clr, // Return to default state.
  input wire pin_in, // Synchronised pin level.
  input wire dir_out, // One makes the pin an output.
  input wire out_val, // Level to drive when output.
  input wire rise_en, // Event on rising edge.
  input wire fall_en, // Event on falling edge.
  output reg event_p // One-cycle event pulse.
);
  reg last_r;

  // Edge detection on the already filtered level; output pins raise no events.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'b0;
      event_p <= 1'b0;
    end else if (clr) begin
      last_r <= pin_in;
      event_p <= 1'b0;
    end else begin
      last_r <= pin_in;
      event_p <= !dir_out && ((rise_en && pin_in && !last_r) || (fall_en && !pin_in && last_r));
    end
  end
endmodule // bsg_gpio_bit

// ### rtl/bsg_strap_gpio.v
// Boot strap capture and general purpose pin block.
// Summary of operation
// R1: Latch all straps on full reset rising.
// R2: Hand strap pins to GPIO after boot.
// R3: GPIO enabled at power-up, all inputs; here GPIO events and drive stay off until hand-over after boot_ok.
// R4: Every pin raises interrupt, DMA event, any core; here pins four and five (serial link id) raise nothing.
// R5: Boot interface auto-enabled from captured selection.
// R6: Disabled peripherals stay off until software enables.
// R7: Emulator reset always honoured.
// R8: Pin zero high little-endian, low big-endian.
// R9: Pins one-three give boot device bits.
// R10: Pins four-five config, then serial link id.
// R11: Pins six-ten give device specific bits.
// R12: Pins eleven-thirteen give PLL or I2C bits.
// R13: Pins fourteen-fifteen give PCIe role.
// R14: Board holds straps defined through full reset.
// R15: Board may tristate drivers using reset status.
// R16: Pins keep default state until software configures.
// R17: Floating straps: pin zero high, others low.
// R18: Full reset pulse restores defaults and recaptures.
// R19: Warm reset keeps captured strap status.
// R20: Straps held in read-only status word.
`timescale 1ns/10ps
`include "bsg_defs.vh"
module bsg_strap_gpio (
  input wire clk, // System clock, 125 MHz.
  input wire rst_n, // Power-on reset, active low, asynchronous.
  input wire full_reset_n, // Full reset pin, active low.
  input wire warm_reset_n, // Warm reset pin, active low.
  input wire emu_reset_req, // Emulator reset request level.
  input wire boot_ok, // Boot loader reports success.
  input wire [15:0] pin_in, // Pad input levels.
  input wire [15:0] sw_dir, // Software direction, one is output.
  input wire [15:0] sw_out, // Software output levels.
  input wire [15:0] sw_rise_en, // Rising edge event enables.
  input wire [15:0] sw_fall_en, // Falling edge event enables.
  input wire [15:0] sw_core_sel, // Route: zero to core 0, one to core 1.
  input wire [2:0] sw_periph_en, // Software enables: srio, eth, i2c.
  output reg [15:0] pin_out, // Pad output levels.
  output reg [15:0] pin_oe, // Pad output enables, high drives.
  output reg [15:0] pull_up, // Pad pull-up enables.
  output reg [15:0] pull_dn, // Pad pull-down enables.
  output reg [15:0] strap_status, // Captured straps, read-only.
  output reg byte_order_le, // One selects little-endian.
  output reg [2:0] boot_dev_sel, // Boot device select.
  output reg [1:0] serial_link_id_select, // Serial link identifier.
  output reg [4:0] dev_spec_cfg, // Device specific configuration.
  output reg [2:0] pll_i2c_cfg, // PLL multiplier or I2C settings.
  output reg [1:0] pcie_role, // PCIe endpoint or root complex.
  output reg [2:0] periph_en, // Enables: srio, eth, i2c.
  output reg [15:0] core0_irq, // Pin interrupts to core 0.
  output reg [15:0] core1_irq, // Pin interrupts to core 1.
  output reg [15:0] dma_trigger_engine, // DMA trigger events.
  output reg reset_status_n, // Low while the device is in reset.
  output reg gpio_ready // Pins handed to general purpose use.
);
  // Reset release, sequencing, capture edge and hand-over state.
  reg rs1_r;
  reg rs2_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [3:0] cnt_r;
  reg fr_last_r;
  reg gp_live_r;
  // Synchronised pins and controls, and the reset sources they feed.
  wire rst_int_n;
  wire [15:0] pin_s;
  wire [3:0] ctl_s;
  wire [15:0] evt;
  wire fr_n;
  wire wr_n;
  wire emu;
  wire ok;
  wire full_rise;
  wire in_reset;

  // Sized copies of the counter load and the link id mask; a bare macro literal cannot be
  // bit-selected, and the load must be cut to the counter's four bits on purpose.
  localparam [31:0] INIT_LOAD = `BSG_INIT_CYC - 1;
  localparam [15:0] SERIAL_LINK_ID_SELECT_MASK = `BSG_SERIAL_LINK_ID_SELECT_MASK;

  // Reset release through two flops so internal logic leaves reset cleanly.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_int_n = rs2_r;

  // Pad and control pins arrive asynchronously; floating-pin pulls give 16'h0001. [R17]
  bsg_sync3 #(.W(16), .RST(`BSG_STRAP_RST)) u_pins (
    .clk(clk),
    .rst_n(rst_int_n),
    .d(pin_in),
    .q(pin_s)
  );
  bsg_sync3 #(.W(4), .RST(16'h0003)) u_ctl (
    .clk(clk),
    .rst_n(rst_int_n),
    .d({boot_ok, emu_reset_req, warm_reset_n, full_reset_n}),
    .q(ctl_s)
  );
  assign fr_n = ctl_s[0];
  assign wr_n = ctl_s[1];
  assign emu = ctl_s[2];
  assign ok = ctl_s[3];
  assign full_rise = fr_n && !fr_last_r;
  // Emulator reset cannot be blocked by any strap setting. [R7]
  assign in_reset = !fr_n || !wr_n || emu;

  // Reset sequencing: hold, short initialisation, then run.
  always @* begin
    st_nxt = st_r;
    case (st_r)
      `BSG_ST_RESET: begin
        if (!in_reset) begin
          st_nxt = `BSG_ST_INIT;
        end
      end
      `BSG_ST_INIT: begin
        if (in_reset) begin
          st_nxt = `BSG_ST_RESET;
        end else if (cnt_r == 4'h0) begin
          st_nxt = `BSG_ST_RUN;
        end
      end
      `BSG_ST_RUN: begin
        if (in_reset) begin
          st_nxt = `BSG_ST_RESET;
        end
      end
      default: begin
        st_nxt = `BSG_ST_RESET;
      end
    endcase
  end

  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_r <= `BSG_ST_RESET;
      cnt_r <= 4'h0;
      fr_last_r <= 1'b1; // Matches the synchroniser's idle level, so reset gives no false capture.
      reset_status_n <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fr_last_r <= fr_n;
      if (st_nxt == `BSG_ST_INIT && st_r != `BSG_ST_INIT) begin
        cnt_r <= INIT_LOAD[3:0];
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
      // Board drivers can tristate while this is low. [R15]
      reset_status_n <= (st_nxt == `BSG_ST_RUN);
    end
  end

  // Capture only on the full reset rising edge; warm reset leaves the word alone. [R1] [R19] [R20]
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      strap_status <= `BSG_STRAP_RST;
    end else if (full_rise) begin
      strap_status <= pin_s; // [R18]
    end
  end

  // Decoded straps follow the status word field by field.
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      byte_order_le <= 1'b1;
      boot_dev_sel <= 3'h0;
      serial_link_id_select <= 2'h0;
      dev_spec_cfg <= 5'h00;
      pll_i2c_cfg <= 3'h0;
      pcie_role <= 2'h0;
    end else begin
      byte_order_le <= strap_status[`BSG_BYTE_ORDER_BIT]; // [R8]
      boot_dev_sel <= strap_status[`BSG_BOOTDEV_MSB:`BSG_BOOTDEV_LSB]; // [R9]
      serial_link_id_select <= strap_status[`BSG_DEVCFG_MSB:`BSG_DEVCFG_LSB]; // [R10]
      dev_spec_cfg <= strap_status[`BSG_DEVSPEC_MSB:`BSG_DEVSPEC_LSB]; // [R11]
      pll_i2c_cfg <= strap_status[`BSG_PLLI2C_MSB:`BSG_PLLI2C_LSB]; // [R12]
      pcie_role <= strap_status[`BSG_PCIE_MSB:`BSG_PCIE_LSB]; // [R13]
    end
  end

  // Peripheral that the captured boot selection switches on by itself, one bit each.
  // Codes outside the three boot interfaces enable nothing, so software keeps control.
  function [2:0] boot_auto_en;
    input [2:0] sel;
    begin
      case (sel)
        `BSG_BOOT_SRIO: boot_auto_en = 3'h1;
        `BSG_BOOT_ETH: boot_auto_en = 3'h2;
        `BSG_BOOT_I2C: boot_auto_en = 3'h4;
        default: boot_auto_en = 3'h0;
      endcase
    end
  endfunction

  // Boot interface switches on by itself; others wait for software. [R5] [R6]
  // The gate looks at the next state so that enables drop on the same edge as reset status.
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      periph_en <= 3'h0;
    end else if (st_nxt != `BSG_ST_RUN) begin
      periph_en <= 3'h0;
    end else begin
      periph_en <= sw_periph_en | boot_auto_en(boot_dev_sel); // [R5] [R6]
    end
  end

  // Hand-over happens only after a successful boot and outside reset. [R2]
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      gp_live_r <= 1'b0;
      gpio_ready <= 1'b0;
    end else begin
      gp_live_r <= (st_r == `BSG_ST_RUN) && ok;
      // Trails the live flag by one cycle, so it rises and falls together with pin_oe.
      gpio_ready <= gp_live_r;
    end
  end

  // Per-pin event logic; pins four and five are serial link id and raise nothing. [R4]
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_pin
      bsg_gpio_bit u_bit (
        .clk(clk),
        .rst_n(rst_int_n),
        .clr(!gp_live_r),
        .pin_in(pin_s[i]),
        .dir_out(sw_dir[i]),
        .out_val(sw_out[i]),
        .rise_en(sw_rise_en[i] && !SERIAL_LINK_ID_SELECT_MASK[i]),
        .fall_en(sw_fall_en[i] && !SERIAL_LINK_ID_SELECT_MASK[i]),
        .event_p(evt[i])
      );
    end
  endgenerate

  // Pad drive: inputs at power-up, defaults held until software asks otherwise. [R3] [R16]
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pin_oe <= 16'h0000;
      pin_out <= 16'h0000;
      pull_up <= `BSG_STRAP_RST;
      pull_dn <= ~`BSG_STRAP_RST;
      core0_irq <= 16'h0000;
      core1_irq <= 16'h0000;
      dma_trigger_engine <= 16'h0000;
    end else begin
      pull_up <= `BSG_STRAP_RST; // [R17]
      pull_dn <= ~`BSG_STRAP_RST;
      if (gp_live_r) begin
        pin_oe <= sw_dir & ~`BSG_SERIAL_LINK_ID_SELECT_MASK; // [R10]
        pin_out <= sw_out & ~`BSG_SERIAL_LINK_ID_SELECT_MASK;
      end else begin
        pin_oe <= 16'h0000; // [R14]
        pin_out <= 16'h0000;
      end
      core0_irq <= evt & ~sw_core_sel; // [R4]
      core1_irq <= evt & sw_core_sel;
      dma_trigger_engine <= evt;
    end
  end
endmodule // bsg_strap_gpio

// ### sim/bsg_strap_props_properties.sv
// Checker for the boot strap capture block.
`timescale 1ns/10ps
module bsg_strap_props (
  input wire clk, // Clock.
  input wire rst_n, // Power-on reset.
  input wire full_reset_n, // Full reset.
  input wire emu_reset_req, // Emulator request.
  input wire [15:0] sw_dir, // Directions.
  input wire gpio_ready, // Hand-over.
  input wire [15:0] pin_oe, // Drive enables.
  input wire [15:0] pull_up, // Pull-ups.
  input wire [15:0] pull_dn, // Pull-downs.
  input wire [15:0] strap_status, // Straps.
  input wire byte_order_le, // Byte order.
  input wire [2:0] boot_dev_sel, // Boot device.
  input wire [1:0] serial_link_id_select, // Link id.
  input wire [4:0] dev_spec_cfg, // Device bits.
  input wire [2:0] pll_i2c_cfg, // PLL bits.
  input wire [1:0] pcie_role, // PCIe role.
  input wire [2:0] periph_en, // Enables.
  input wire reset_status_n // Reset status.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles since full reset was low; a capture may only land in that window.
  reg [7:0] since_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_r <= 8'hff;
    else if (!full_reset_n) since_r <= 8'h00;
    else if (since_r != 8'hff) since_r <= since_r + 8'h01;
  end
  sequence s_fall; $fell(full_reset_n); endsequence
  sequence s_low; !reset_status_n; endsequence
  a_strap_hold: assert property ($changed(strap_status) |-> since_r < 8'h0c)
    else $error("strap status changed outside a capture");
  a_endian_dec: assert property (byte_order_le == $past(strap_status[0]))
    else $error("byte order decode wrong");
  a_boot_dec: assert property ({serial_link_id_select, boot_dev_sel} == $past(strap_status[5:1]))
    else $error("boot device decode wrong");
  a_cfg_dec: assert property ({pcie_role, pll_i2c_cfg, dev_spec_cfg} == $past(strap_status[15:6]))
    else $error("configuration decode wrong");
  a_oe_gated: assert property (!gpio_ready |-> pin_oe == 16'h0000)
    else $error("pin driven before hand-over");
  a_link_pins: assert property (pin_oe[5:4] == 2'h0)
    else $error("link id pin driven");
  a_pulls_fixed: assert property (pull_up == 16'h0001 && pull_dn == 16'hfffe)
    else $error("pull setting wrong");
  a_periph_off: assert property (!reset_status_n |-> periph_en == 3'h0)
    else $error("peripheral enabled in reset");
  a_handover_dir: assert property ($rose(gpio_ready) |-> ##[0:3] pin_oe == (sw_dir & 16'hffcf))
    else $error("directions not applied at hand-over");
  a_emu_honour: assert property ($rose(emu_reset_req) |-> ##[1:8] !reset_status_n)
    else $error("emulator reset ignored");
  a_full_restart: assert property (s_fall |-> ##[1:8] s_low)
    else $error("full reset ignored");
endmodule // bsg_strap_props
bind bsg_strap_gpio bsg_strap_props i_bsg_strap_props (.clk(clk), .rst_n(rst_n),
  .full_reset_n(full_reset_n), .emu_reset_req(emu_reset_req), .sw_dir(sw_dir),
  .gpio_ready(gpio_ready), .pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(pull_dn),
  .strap_status(strap_status), .byte_order_le(byte_order_le), .boot_dev_sel(boot_dev_sel),
  .serial_link_id_select(serial_link_id_select), .dev_spec_cfg(dev_spec_cfg),
  .pll_i2c_cfg(pll_i2c_cfg), .pcie_role(pcie_role), .periph_en(periph_en),
  .reset_status_n(reset_status_n));

// ### sim/bsg_board_model.sv
// Board model that drives the straps and resolves each pad level.
`timescale 1ns/10ps
module bsg_board_model (
  input wire por_n, // Power-on reset seen by the board.
  input wire drv_en, // Board drivers on.
  input wire [15:0] drv_val, // Levels the board drives.
  input wire [15:0] pin_out, // Device pad levels.
  input wire [15:0] pin_oe, // Device drive enables.
  input wire [15:0] pull_up, // Device pull-ups.
  output wire [15:0] pad // Resolved pad levels.
);
  // Drivers float while power-on reset is low, so no fight at power-up.
  wire [15:0] brd = (drv_en && por_n) ? 16'hffff : 16'h0000;
  // Device drive wins, then the board, then the internal pull.
  assign pad = (pin_oe & pin_out) | (~pin_oe & brd & drv_val) | (~pin_oe & ~brd & pull_up);
endmodule // bsg_board_model

// ### sim/tb_bsg_strap_gpio.sv
// Self-checking bench for the boot strap capture block.
`timescale 1ns/10ps
module tb_bsg_strap_gpio;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg full_reset_n = 1'b0;
  reg warm_reset_n = 1'b1;
  reg emu_reset_req = 1'b0;
  reg boot_ok = 1'b0;
  reg drv_en = 1'b0;
  reg [15:0] drv_val = 16'h0000;
  reg [15:0] sw_dir = 16'h0000;
  reg [15:0] sw_out = 16'h0000;
  reg [15:0] sw_rise_en = 16'h0000;
  reg [15:0] sw_fall_en = 16'h0000;
  reg [15:0] sw_core_sel = 16'h0000;
  reg [2:0] sw_periph_en = 3'h0;
  wire [15:0] pad, pin_out, pin_oe, pull_up, strap_status, core0_irq, core1_irq, dma;
  wire [2:0] boot_dev_sel, pll_i2c_cfg, periph_en;
  wire [1:0] link_id, pcie_role;
  wire [4:0] dev_spec_cfg;
  wire byte_order_le, reset_status_n, gpio_ready;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  integer k;
  reg [15:0] v;
  bsg_strap_gpio i_bsg_strap_gpio (.clk(clk), .rst_n(rst_n), .full_reset_n(full_reset_n),
    .warm_reset_n(warm_reset_n), .emu_reset_req(emu_reset_req), .boot_ok(boot_ok),
    .pin_in(pad), .sw_dir(sw_dir), .sw_out(sw_out), .sw_rise_en(sw_rise_en),
    .sw_fall_en(sw_fall_en), .sw_core_sel(sw_core_sel), .sw_periph_en(sw_periph_en),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(),
    .strap_status(strap_status), .byte_order_le(byte_order_le), .boot_dev_sel(boot_dev_sel),
    .serial_link_id_select(link_id), .dev_spec_cfg(dev_spec_cfg), .pll_i2c_cfg(pll_i2c_cfg),
    .pcie_role(pcie_role), .periph_en(periph_en), .core0_irq(core0_irq),
    .core1_irq(core1_irq), .dma_trigger_engine(dma), .reset_status_n(reset_status_n),
    .gpio_ready(gpio_ready));
  bsg_board_model i_bsg_board_model (.por_n(rst_n), .drv_en(drv_en), .drv_val(drv_val),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pad(pad));
  // Free-running system clock.
  always #4 clk = ~clk;
  // Cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Waits, bounded, until the device leaves reset.
  task wait_run;
    begin
      step(12);
      i = 0;
      while (reset_status_n !== 1'b1 && i < 64) begin
        step(1);
        i = i + 1;
      end
      chk({15'h0, reset_status_n}, 16'h0001);
      step(2);
    end
  endtask
  // Straps stay steady well before and through the rising edge.
  task full_pulse(input [15:0] val, input d);
    begin
      drv_val = val;
      drv_en = d;
      step(6);
      full_reset_n = 1'b0;
      step(6);
      full_reset_n = 1'b1;
      wait_run;
    end
  endtask
  task t_capture;
    begin
      full_pulse(16'hffff, 1'b0);
      chk(strap_status, 16'h0001);
      chk(pin_oe, 16'h0000);
      for (k = 0; k < 2; k = k + 1) begin
        v = (k == 0) ? 16'hfffe : 16'h5a35;
        full_pulse(v, 1'b1);
        chk(strap_status, v);
        chk({byte_order_le, boot_dev_sel, link_id, dev_spec_cfg, pll_i2c_cfg, pcie_role},
          {v[0], v[3:1], v[5:4], v[10:6], v[13:11], v[15:14]});
      end
      $display("capture test done");
    end
  endtask
  task t_resets;
    begin
      drv_val = 16'h0f0f;
      warm_reset_n = 1'b0;
      step(4);
      warm_reset_n = 1'b1;
      wait_run;
      chk(strap_status, 16'h5a35);
      emu_reset_req = 1'b1;
      step(4);
      emu_reset_req = 1'b0;
      wait_run;
      chk(strap_status, 16'h5a35);
      $display("reset test done");
    end
  endtask
  task t_periph;
    begin
      for (k = 1; k < 4; k = k + 1) begin
        v = k[15:0];
        full_pulse({12'h000, v[2:0], 1'b0}, 1'b1);
        chk({13'h0, periph_en}, 16'h0001 << (k - 1));
      end
      sw_periph_en = 3'h3;
      step(4);
      chk({13'h0, periph_en}, 16'h0007);
      $display("peripheral test done");
    end
  endtask
  // Waits, bounded, for an event pulse on pin seven and checks its routing.
  task ev_wait(input [15:0] exp);
    begin
      i = 0;
      while (dma[7] !== 1'b1 && i < 16) begin
        step(1);
        i = i + 1;
      end
      chk({13'h0, core1_irq[7], dma[7], core0_irq[7]}, exp);
    end
  endtask
  task t_gpio;
    begin
      drv_val = 16'h0000;
      sw_dir = 16'h0031;
      sw_out = 16'h0011;
      boot_ok = 1'b1;
      step(12);
      chk({15'h0, gpio_ready}, 16'h0001);
      chk(pin_oe, 16'h0001);
      chk(pin_out & pin_oe, 16'h0001);
      sw_rise_en = 16'h0080;
      sw_core_sel = 16'h0080;
      step(3);
      drv_val = 16'h0080;
      ev_wait(16'h0006);
      sw_fall_en = 16'h0080;
      sw_core_sel = 16'h0000;
      step(3);
      drv_val = 16'h0000;
      ev_wait(16'h0003);
      $display("gpio test done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Main sequence.
  initial begin
    step(2);
    rst_n = 1'b1;
    step(2);
    t_capture;
    t_resets;
    t_periph;
    t_gpio;
    close_out;
  end
endmodule // tb_bsg_strap_gpio
